// File: design/madc_pkg.sv
package madc_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CH_W = 5;
  localparam int DATA_W = 12;
  localparam int NCH = 19;          // Channels 0..18 on each converter
  localparam int EXT_CH_TOTAL = 39; // External inputs over all four converters
  localparam int NAWD = 3;
  localparam int NSLOT = 8;
  localparam int NST = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int ILV_DLY_NS = 20;   // Partner start offset, interleaved mode
  localparam int ILV_DLY_CYC = (ILV_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_IMASK = 8'h08;
  localparam logic [7:0] OFF_DIFF = 8'h0C;
  localparam logic [7:0] OFF_SQLEN = 8'h10;
  localparam logic [7:0] OFF_SQ0 = 8'h14;
  localparam logic [7:0] OFF_SQ1 = 8'h18;
  localparam logic [7:0] OFF_JSQ = 8'h1C;
  localparam logic [7:0] OFF_DATA = 8'h20;
  localparam logic [7:0] OFF_JDATA = 8'h24;
  localparam logic [7:0] OFF_STATE = 8'h28;
  localparam logic [7:0] OFF_AWD_THR = 8'h30;
  localparam logic [7:0] OFF_AWD_CH = 8'h40;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C_EN = 0;
  localparam int C_SCAN = 1;
  localparam int C_START = 2;
  localparam int C_RES = 3;     // Two bits
  localparam int C_DUAL = 5;    // Two bits
  localparam int C_DMA = 7;
  localparam int C_RTEN = 8;
  localparam int C_JTEN = 9;
  localparam int C_RSEL = 10;   // Three bits
  localparam int C_JSEL = 13;   // Three bits
  localparam int C_JSTART = 16;
  localparam int SQ_JLEN = 8;
  localparam int THR_HI = 16;
  localparam int S_EOC = 0;
  localparam int S_EOS = 1;
  localparam int S_JEOS = 2;
  localparam int S_AWD = 3;     // Three bits
  localparam int S_OVR = 6;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [31:0] THR_RST = 32'h0FFF_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_FFFB;
  localparam logic [31:0] DIFF_WMASK = 32'h0007_FFFF;
  localparam logic [31:0] SQ_WMASK = 32'h1F1F_1F1F;
  localparam logic [31:0] SQLEN_WMASK = 32'h0000_0107;
  localparam logic [11:0] FULL_MASK = 12'hFFF;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DUAL_INDEP = 2'h0;
  localparam logic [1:0] DUAL_SIMUL = 2'h1;
  localparam logic [1:0] DUAL_ILV = 2'h2;
  localparam logic [2:0] SRC_EXT = 3'h0;
  localparam logic [2:0] SRC_TEMP = 3'h1;
  localparam logic [2:0] SRC_VBAT_HALF = 3'h2;
  localparam logic [2:0] SRC_BGAP = 3'h3;
  localparam logic [2:0] SRC_AMPREF = 3'h4;
  localparam logic [4:0] CH_AMPREF_FIRST = 5'h0F;
  localparam logic [4:0] CH_TEMP = 5'h10;
  localparam logic [4:0] CH_BATT = 5'h11;
  localparam logic [4:0] CH_AMPREF = 5'h11;
  localparam logic [4:0] CH_BGAP = 5'h12;
endpackage

// File: design/madc_chan_map.sv
`timescale 1ns/1ps
module madc_chan_map #(
  parameter int CONV_IDX = 1 // Converter number, 1 to 4
) (
  input wire logic [madc_pkg::CH_W-1:0] chan, // Channel being converted
  output logic [2:0] src                      // Analog source select code
);
  import madc_pkg::*;

  // ----------------------------------------------------------------
  // Internal source mapping
  // ----------------------------------------------------------------
  // The battery source selects the divide-by-two bridge, so its code is half the level
  wire is_first = (CONV_IDX == 1);
  wire temp_hit = is_first && (chan == CH_TEMP);
  wire batt_hit = is_first && (chan == CH_BATT);
  wire bgap_hit = (chan == CH_BGAP);
  wire ampr_hit = is_first ? (chan == CH_AMPREF_FIRST) : (chan == CH_AMPREF);

  assign src = temp_hit ? SRC_TEMP :
               batt_hit ? SRC_VBAT_HALF :
               bgap_hit ? SRC_BGAP :
               ampr_hit ? SRC_AMPREF : SRC_EXT;
endmodule // madc_chan_map

// File: design/madc_awd.sv
`timescale 1ns/1ps
module madc_awd (
  input wire logic res_vld,                        // New result this cycle
  input wire logic [madc_pkg::CH_W-1:0] res_chan,  // Channel of the result
  input wire logic [madc_pkg::DATA_W-1:0] res_data, // Result code
  input wire logic [31:0] thr,                      // Low in 11:0, high in 27:16
  input wire logic [31:0] ch_sel,                   // One bit per monitored channel
  output logic hit                                  // Out-of-window pulse
);
  import madc_pkg::*;

  // ----------------------------------------------------------------
  // Window compare
  // ----------------------------------------------------------------
  // Channel bits above the channel count are never written, so they stay clear
  wire [DATA_W-1:0] lo = thr[DATA_W-1:0];
  wire [DATA_W-1:0] hi = thr[THR_HI +: DATA_W];
  wire watched = ch_sel[res_chan];
  wire outside = (res_data < lo) || (res_data > hi);

  assign hit = res_vld && watched && outside;
endmodule // madc_awd

// File: design/madc_ctrl.sv
`timescale 1ns/1ps
module madc_ctrl #(
  parameter int CONV_IDX = 1, // Converter number, 1 to 4
  parameter int NTRIG = 8     // Trigger inputs per timer group
) (
  input wire logic clk,                              // System clock
  input wire logic sys_rst,                          // Synchronous reset
  input wire logic psel,                             // APB select
  input wire logic penable,                          // APB enable
  input wire logic pwrite,                           // APB direction
  input wire logic [7:0] paddr,                      // APB byte address
  input wire logic [31:0] pwdata,                    // APB write data
  output logic [31:0] prdata,                        // APB read data
  output logic pready,                               // APB ready
  output logic pslverr,                              // APB error
  input wire logic [NTRIG-1:0] gp_trig,              // General-purpose timer events
  input wire logic [NTRIG-1:0] adv_trig,             // Advanced timer events
  input wire logic conv_done,                        // Analog core result ready
  input wire logic [madc_pkg::DATA_W-1:0] conv_data, // Analog core result
  output logic conv_start_q,                         // Start pulse to core
  output logic [madc_pkg::CH_W-1:0] conv_chan_q,     // Channel to convert
  output logic conv_diff_q,                          // Differential input
  output logic [1:0] conv_res_q,                     // Resolution code
  output logic [2:0] conv_src_q,                     // Internal source select
  output logic slave_start_q,                        // Start pulse to partner
  input wire logic dma_ack,                          // DMA took the result
  output logic dma_req_q,                            // DMA request level
  output logic [madc_pkg::DATA_W-1:0] dma_data_q,    // Result for DMA
  output logic irq_q                                 // Interrupt level
);
  import madc_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_RGO, S_RWAIT, S_JGO, S_JWAIT} madc_state_t;

  madc_state_t st_q, st_d;
  logic [31:0] ctrl_q, imask_q, diff_q, sqlen_q, sq0_q, sq1_q, jsq_q;
  logic [NST-1:0] stat_q, stat_d, ev;
  logic [2:0] slot_q, slot_d;
  logic jslot_q, jslot_d, r_act_q, r_act_d, jpend_q;
  logic rtrig_prev_q, jtrig_prev_q, data_vld_q;
  logic [DATA_W-1:0] jdata_q;
  logic [3:0] ilv_cnt_q;
  logic [31:0] rd_mux;
  logic [31:0] awd_thr_q [NAWD];
  logic [31:0] awd_ch_q [NAWD];
  logic [NAWD-1:0] awd_hit, awd_sel;
  logic [31:0] awd_rd [NAWD];
  logic [31:0] awd_rd_or;
  logic [2:0] map_src;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Two-cycle access: ready is high in the second access cycle, and the effect lands at the end of it
  wire acc = psel && penable;
  wire wr_fire = acc && pready && pwrite;
  wire rd_fire = acc && pready && !pwrite;
  wire a_ctrl = (paddr == OFF_CTRL);
  wire a_stat = (paddr == OFF_STAT);
  wire a_imask = (paddr == OFF_IMASK);
  wire a_diff = (paddr == OFF_DIFF);
  wire a_sqlen = (paddr == OFF_SQLEN);
  wire a_sq0 = (paddr == OFF_SQ0);
  wire a_sq1 = (paddr == OFF_SQ1);
  wire a_jsq = (paddr == OFF_JSQ);
  wire a_data = (paddr == OFF_DATA);
  wire a_jdata = (paddr == OFF_JDATA);
  wire a_state = (paddr == OFF_STATE);
  wire fixed_hit = a_ctrl | a_stat | a_imask | a_diff | a_sqlen | a_sq0 | a_sq1 | a_jsq
                   | a_data | a_jdata | a_state;
  wire map_hit = fixed_hit | (|awd_sel);

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire en = ctrl_q[C_EN];
  wire scan = ctrl_q[C_SCAN];
  wire [1:0] res = ctrl_q[C_RES +: 2];
  wire [1:0] dual = ctrl_q[C_DUAL +: 2];
  wire dma_en = ctrl_q[C_DMA];
  wire [2:0] rsel = ctrl_q[C_RSEL +: 3];
  wire [2:0] jsel = ctrl_q[C_JSEL +: 3];
  wire [2:0] rlen = sqlen_q[2:0];
  wire jlen = sqlen_q[SQ_JLEN];
  wire sw_start = wr_fire && a_ctrl && pwdata[C_START];
  wire sw_jstart = wr_fire && a_ctrl && pwdata[C_JSTART];

  // ----------------------------------------------------------------
  // Trigger selection and edge detection
  // ----------------------------------------------------------------
  // Timer events come from logic on this clock, so no synchroniser is needed
  wire rtrig_cur = gp_trig[rsel];
  wire jtrig_cur = adv_trig[jsel];
  wire rtrig_edge = ctrl_q[C_RTEN] && rtrig_cur && !rtrig_prev_q;
  wire jtrig_edge = ctrl_q[C_JTEN] && jtrig_cur && !jtrig_prev_q;
  wire rstart = en && (sw_start || rtrig_edge);
  wire jtrig = en && (sw_jstart || jtrig_edge);

  // ----------------------------------------------------------------
  // Sequence slot selection
  // ----------------------------------------------------------------
  wire [31:0] sq_word = slot_q[2] ? sq1_q : sq0_q;
  wire [CH_W-1:0] rchan = sq_word[{slot_q[1:0], 3'h0} +: CH_W];
  wire [CH_W-1:0] jchan = jsq_q[{jslot_q, 3'h0} +: CH_W];
  wire in_jgo = (st_q == S_JGO);
  wire in_rgo = (st_q == S_RGO);
  wire [CH_W-1:0] cur_chan = in_jgo ? jchan : rchan;
  wire r_last = !scan || (slot_q == rlen);
  wire j_last = (jslot_q == jlen);
  wire rdone = (st_q == S_RWAIT) && conv_done;
  wire jdone = (st_q == S_JWAIT) && conv_done;
  wire jtake = in_jgo && !jslot_q;

  // ----------------------------------------------------------------
  // Result shaping
  // ----------------------------------------------------------------
  // Bits below the chosen resolution are cleared so a stale low bit never leaks out
  wire [DATA_W-1:0] res_mask = FULL_MASK << {res, 1'b0};
  wire [DATA_W-1:0] result = conv_data & res_mask;
  wire vld_clr = (dma_ack && dma_req_q) || (rd_fire && a_data);
  wire data_vld_d = rdone || (data_vld_q && !vld_clr);

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    slot_d = slot_q;
    jslot_d = jslot_q;
    r_act_d = r_act_q;
    case (st_q)
      S_IDLE:
        if (jpend_q)
          st_d = S_JGO;
        else if (rstart)
        begin
          st_d = S_RGO;
          r_act_d = 1'b1;
          slot_d = 3'h0;
        end
      S_RGO:
        st_d = S_RWAIT;
      S_RWAIT:
        if (conv_done)
        begin
          // A pending injected run waits for the current regular result, never aborts it
          if (r_last)
          begin
            slot_d = 3'h0;
            r_act_d = 1'b0;
            st_d = jpend_q ? S_JGO : S_IDLE;
          end
          else
          begin
            slot_d = slot_q + 3'h1;
            st_d = jpend_q ? S_JGO : S_RGO;
          end
        end
      S_JGO:
        st_d = S_JWAIT;
      S_JWAIT:
        if (conv_done)
        begin
          if (j_last)
          begin
            jslot_d = 1'b0;
            st_d = r_act_q ? S_RGO : S_IDLE;
          end
          else
          begin
            jslot_d = 1'b1;
            st_d = S_JGO;
          end
        end
      default:
        st_d = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  // A new injected trigger during an injected run is kept and served afterwards
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= S_IDLE;
      slot_q <= 3'h0;
      jslot_q <= 1'b0;
      r_act_q <= 1'b0;
      jpend_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      slot_q <= slot_d;
      jslot_q <= jslot_d;
      r_act_q <= r_act_d;
      jpend_q <= jtrig || (jpend_q && !jtake);
    end
  end

  // ----------------------------------------------------------------
  // Channel map
  // ----------------------------------------------------------------
  madc_chan_map #(
    .CONV_IDX(CONV_IDX)
  ) u_map (
    .chan(cur_chan),
    .src(map_src)
  );

  // ----------------------------------------------------------------
  // Converter drive
  // ----------------------------------------------------------------
  // Channel, mode and start all change on the same edge, so the core sees them together
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      conv_start_q <= 1'b0;
      conv_chan_q <= '0;
      conv_diff_q <= 1'b0;
      conv_res_q <= 2'h0;
      conv_src_q <= SRC_EXT;
    end
    else
    begin
      conv_start_q <= in_rgo || in_jgo;
      conv_res_q <= res;
      if (in_rgo || in_jgo)
      begin
        conv_chan_q <= cur_chan;
        conv_diff_q <= diff_q[cur_chan];
        conv_src_q <= map_src;
      end
    end
  end

  // ----------------------------------------------------------------
  // Partner converter start
  // ----------------------------------------------------------------
  // Simultaneous mode also covers injected runs, which single-shunt current reading needs
  wire ilv_load = in_rgo && (dual == DUAL_ILV);
  wire simul_go = (dual == DUAL_SIMUL) && (in_rgo || in_jgo);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ilv_cnt_q <= 4'h0;
      slave_start_q <= 1'b0;
    end
    else
    begin
      ilv_cnt_q <= ilv_load ? 4'(ILV_DLY_CYC) : (ilv_cnt_q != 4'h0) ? ilv_cnt_q - 4'h1 : 4'h0;
      slave_start_q <= simul_go || (ilv_cnt_q == 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // Results, DMA handover and trigger history
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dma_data_q <= '0;
      jdata_q <= '0;
      data_vld_q <= 1'b0;
      dma_req_q <= 1'b0;
      rtrig_prev_q <= 1'b0;
      jtrig_prev_q <= 1'b0;
    end
    else
    begin
      if (rdone)
        dma_data_q <= result;
      if (jdone)
        jdata_q <= result;
      data_vld_q <= data_vld_d;
      dma_req_q <= dma_en && data_vld_d;
      rtrig_prev_q <= rtrig_cur;
      jtrig_prev_q <= jtrig_cur;
    end
  end

  // ----------------------------------------------------------------
  // Watchdogs with their threshold and channel registers
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < NAWD; i++)
    begin : g_awd
      wire a_thr = (paddr == OFF_AWD_THR + 8'(4 * i));
      wire a_ch = (paddr == OFF_AWD_CH + 8'(4 * i));
      assign awd_sel[i] = a_thr | a_ch;
      assign awd_rd[i] = a_thr ? awd_thr_q[i] : a_ch ? awd_ch_q[i] : 32'h0000_0000;

      // Threshold and channel set
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          awd_thr_q[i] <= THR_RST;
          awd_ch_q[i] <= REG_RST;
        end
        else if (wr_fire && a_thr)
          awd_thr_q[i] <= pwdata & {4'h0, FULL_MASK, 4'h0, FULL_MASK};
        else if (wr_fire && a_ch)
          awd_ch_q[i] <= pwdata & DIFF_WMASK;
      end

      madc_awd u_awd (
        .res_vld(rdone || jdone),
        .res_chan(conv_chan_q),
        .res_data(result),
        .thr(awd_thr_q[i]),
        .ch_sel(awd_ch_q[i]),
        .hit(awd_hit[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status events and interrupt
  // ----------------------------------------------------------------
  // Overrun: a regular result lands while the previous one was still unclaimed
  always_comb
  begin
    ev = '0;
    ev[S_EOC] = rdone;
    ev[S_EOS] = rdone && r_last;
    ev[S_JEOS] = jdone && j_last;
    ev[S_AWD +: NAWD] = awd_hit;
    ev[S_OVR] = rdone && data_vld_q && !vld_clr;
    stat_d = ev | (stat_q & ~((wr_fire && a_stat) ? pwdata[NST-1:0] : '0));
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= REG_RST;
      imask_q <= REG_RST;
      diff_q <= REG_RST;
      sqlen_q <= REG_RST;
      sq0_q <= REG_RST;
      sq1_q <= REG_RST;
      jsq_q <= REG_RST;
      stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (wr_fire && a_ctrl)
        ctrl_q <= pwdata & CTRL_WMASK;
      if (wr_fire && a_imask)
        imask_q <= {25'h0, pwdata[NST-1:0]};
      if (wr_fire && a_diff)
        diff_q <= pwdata & DIFF_WMASK;
      if (wr_fire && a_sqlen)
        sqlen_q <= pwdata & SQLEN_WMASK;
      if (wr_fire && a_sq0)
        sq0_q <= pwdata & SQ_WMASK;
      if (wr_fire && a_sq1)
        sq1_q <= pwdata & SQ_WMASK;
      if (wr_fire && a_jsq)
        jsq_q <= pwdata & {16'h0, SQ_WMASK[15:0]};
      stat_q <= stat_d;
      irq_q <= |(stat_d & imask_q[NST-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    awd_rd_or = '0;
    for (int k = 0; k < NAWD; k++)
      awd_rd_or = awd_rd_or | awd_rd[k];
    case (1'b1)
      a_ctrl: rd_mux = ctrl_q;
      a_stat: rd_mux = {25'h0, stat_q};
      a_imask: rd_mux = imask_q;
      a_diff: rd_mux = diff_q;
      a_sqlen: rd_mux = sqlen_q;
      a_sq0: rd_mux = sq0_q;
      a_sq1: rd_mux = sq1_q;
      a_jsq: rd_mux = jsq_q;
      a_data: rd_mux = {20'h0, dma_data_q};
      a_jdata: rd_mux = {20'h0, jdata_q};
      a_state: rd_mux = {24'h0, data_vld_q, jpend_q, r_act_q, slot_q, st_q != S_IDLE, jslot_q};
      default: rd_mux = awd_rd_or;
    endcase
  end

  // APB answer; unmapped addresses complete with an error and read zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !map_hit;
      prdata <= (acc && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end
endmodule // madc_ctrl

// File: sim/madc_core_model.sv
`timescale 1ns/1ps
// Analog core stand-in, answering each start quickly or slowly in turn
module madc_core_model (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Reset
  input wire logic conv_start_q, // Start pulse
  output logic conv_done, // Result strobe
  output logic [11:0] conv_data // Result
);
  logic [3:0] cnt_q;
  logic slow_q;
  logic [11:0] junk_q;
  // Latency alternates so the controller never sees a fixed answer time
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_q <= 4'h0;
      slow_q <= 1'b0;
    end
    else if (conv_start_q)
    begin
      cnt_q <= slow_q ? 4'h6 : 4'h2;
      slow_q <= ~slow_q;
    end
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    junk_q <= junk_q + 12'h3A7;
  end
  // Data is junk outside the strobe so a stale value cannot pass
  assign conv_done = (cnt_q == 4'h1);
  assign conv_data = conv_done ? 12'hABC : junk_q;
endmodule // madc_core_model

// File: sim/madc_ctrl_asserts.sv
`timescale 1ns/1ps
module madc_ctrl_asserts #(
  parameter int CONV_IDX = 1 // Converter number
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [31:0] prdata, // APB data
  input wire logic conv_start_q, // Start pulse
  input wire logic [madc_pkg::CH_W-1:0] conv_chan_q, // Channel
  input wire logic conv_diff_q, // Differential
  input wire logic [2:0] conv_src_q, // Source code
  input wire logic slave_start_q, // Partner start
  input wire logic dma_ack, // DMA took it
  input wire logic dma_req_q // DMA request
);
  import madc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Access phase is always two cycles, answer lasts one
  sequence s_access;
    psel && penable && !pready;
  endsequence
  AST_RDY: assert property (s_access |=> pready)
    else $error("pready late");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  // Each conversion waits for its result, so starts never crowd
  AST_START_GAP: assert property (conv_start_q |=> !conv_start_q [*2])
    else $error("starts too close");
  AST_HOLD: assert property (!conv_start_q |->
    $stable({conv_chan_q, conv_diff_q, conv_src_q}))
    else $error("setup moved between starts");
  AST_BGAP: assert property (conv_start_q && conv_chan_q == CH_BGAP
    |-> conv_src_q == SRC_BGAP)
    else $error("bandgap not selected");
  AST_BATT: assert property (conv_start_q && conv_chan_q == CH_BATT && CONV_IDX == 1
    |-> conv_src_q == SRC_VBAT_HALF)
    else $error("battery bridge not selected");
  AST_SLAVE: assert property (slave_start_q
    |-> conv_start_q || $past(conv_start_q, ILV_DLY_CYC))
    else $error("partner start out of step");
  AST_DMA: assert property (dma_ack && dma_req_q |-> ##[1:2] !dma_req_q)
    else $error("DMA request not cleared");
endmodule // madc_ctrl_asserts
bind madc_ctrl madc_ctrl_asserts #(.CONV_IDX(CONV_IDX)) u_chk (.clk, .sys_rst, .psel, .penable,
  .pready, .pslverr, .prdata, .conv_start_q, .conv_chan_q, .conv_diff_q, .conv_src_q,
  .slave_start_q, .dma_ack, .dma_req_q);

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import madc_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dma_ack = 1'b0;
  logic [7:0] paddr = 8'h00, gp_trig = 8'h00, adv_trig = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic pready, pslverr, conv_done, conv_start_q, conv_diff_q, slave_start_q, dma_req_q;
  logic irq_q, err;
  logic [11:0] conv_data, dma_data_q;
  logic [4:0] conv_chan_q;
  logic [1:0] conv_res_q;
  logic [2:0] conv_src_q;
  logic [31:0] seen_q[$];
  logic [7:0] exp_s[4];
  int fail_count = 0, n_compared = 0, n_slave = 0;
  madc_ctrl DUT (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .gp_trig, .adv_trig, .conv_done, .conv_data, .conv_start_q, .conv_chan_q,
    .conv_diff_q, .conv_res_q, .conv_src_q, .slave_start_q, .dma_ack, .dma_req_q, .dma_data_q,
    .irq_q);
  madc_core_model u_core (.clk, .sys_rst, .conv_start_q, .conv_done, .conv_data);
  initial forever #2 clk = ~clk;
  // Log the setup handed to the core at every start
  always @(posedge clk)
  begin
    if (conv_start_q === 1'b1)
      seen_q.push_back({21'h0, conv_res_q, conv_diff_q, conv_src_q, conv_chan_q});
    if (slave_start_q === 1'b1) n_slave++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer; waits for pready however long it takes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd_v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait for n starts, then until the converter reports idle
  task automatic run(input int n);
    while (seen_q.size() < n) @(posedge clk);
    do apb(1'b0, OFF_STATE, 32'h0); while (rd_v[1] !== 1'b0);
  endtask
  task automatic t_regs;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd_v, REG_RST);
    apb(1'b0, OFF_AWD_THR + 8'h08, 32'h0);
    chk(rd_v, THR_RST);
    apb(1'b0, 8'h2C, 32'h0);
    chk({err, rd_v[30:0]}, 32'h8000_0000);
  endtask
  task automatic t_scan;
    exp_s = '{{SRC_TEMP, CH_TEMP}, {SRC_VBAT_HALF, CH_BATT}, {SRC_BGAP, CH_BGAP},
      {SRC_AMPREF, CH_AMPREF_FIRST}};
    apb(1'b1, OFF_SQ0, 32'h0F12_1110);
    apb(1'b1, OFF_SQLEN, 32'h3);
    // The start bit is judged against the enable already held, so enable first
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h7);
    run(4);
    for (int i = 0; i < 4; i++) chk(seen_q[i], {24'h0, exp_s[i]});
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rd_v & 32'h2, 32'h2);
    apb(1'b1, OFF_STAT, 32'h7F);
  endtask
  // Six-bit differential shot, out of window, handed to DMA, partner interleaved
  task automatic t_wd;
    seen_q.delete();
    apb(1'b1, OFF_AWD_THR, 32'h0100_0000);
    apb(1'b1, OFF_AWD_CH, 32'h8);
    apb(1'b1, OFF_DIFF, 32'h8);
    apb(1'b1, OFF_IMASK, 32'h8);
    apb(1'b1, OFF_SQ0, 32'h3);
    apb(1'b1, OFF_SQLEN, 32'h0);
    apb(1'b1, OFF_CTRL, 32'hDD);
    run(1);
    chk(seen_q[0], 32'h703);
    chk({20'h0, dma_data_q}, 32'hA80);
    chk({30'h0, irq_q, dma_req_q}, 32'h3);
    @(posedge clk) dma_ack <= 1'b1;
    @(posedge clk) dma_ack <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, dma_req_q}, 32'h0);
    apb(1'b1, OFF_STAT, 32'h7F);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_q}, 32'h0);
    chk(n_slave, 32'h1);
  endtask
  // Timer triggers with the partner started alongside
  task automatic t_trig;
    seen_q.delete();
    n_slave = 0;
    apb(1'b1, OFF_JSQ, {27'h0, CH_BGAP});
    apb(1'b1, OFF_CTRL, 32'h2B21);
    @(posedge clk) gp_trig <= 8'h04;
    @(posedge clk) gp_trig <= 8'h00;
    run(1);
    @(posedge clk) adv_trig <= 8'h02;
    @(posedge clk) adv_trig <= 8'h00;
    run(2);
    chk(seen_q[0], 32'h103);
    chk(seen_q[1], {24'h0, SRC_BGAP, CH_BGAP});
    chk(n_slave, 32'h2);
    apb(1'b0, OFF_JDATA, 32'h0);
    chk(rd_v, 32'hABC);
    // Injected trigger arrives in the same cycle as the trigger of a two-slot scan: it runs between the slots
    seen_q.delete();
    apb(1'b1, OFF_SQLEN, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h2B23);
    @(posedge clk) {gp_trig, adv_trig} <= 16'h0402;
    @(posedge clk) {gp_trig, adv_trig} <= 16'h0000;
    run(3);
    chk(seen_q[1], {24'h0, SRC_BGAP, CH_BGAP});
    chk(seen_q[2], 32'h0);
  endtask
  initial
  begin
    #200000;
    fail_count++;
    stop_test;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_scan;
    t_wd;
    t_trig;
    stop_test;
  end
endmodule // tb_top
